// ---- design/crpf_core.sv ----
/*
 * Command core of the subscriber card record and holder-code functions.
 * Assumes commands arrive one at a time as a one-cycle strobe and that
 * each is answered in the following cycle; file attributes are inputs.
 */
// Behaviour
// - Update runs only if update access holds; failure keeps pointer.
// - Linear files take all four update modes; cyclic only previous.
// - Current and absolute modes write in place without moving a set pointer; absolute sets an unset one on the first record.
// - Next increments then writes; unset means first; last record refuses.
// - Previous decrements then writes; unset means last; first refuses.
// - Cyclic previous writes oldest record, points there, renumbers it one.
// - Search only on linear file with read access, matching record start.
// - Type 1 moves pointer only; type 2 also returns record number.
// - Patterns of 1 to 16 bytes accepted; length not checked against record.
// - Four search modes; unset pointer starts first or last record.
// - Success leaves pointer on match; failure keeps pointer.
// - Increase adds to newest cyclic record, stores in oldest, returns both.
// - Increase refused on overflow past all FF or without access.
// - Verify only when enabled and unblocked; correct restores counter three.
// - Wrong codes decrement; three wrong blocks code until unblocked.
// - Change needs correct old code; installs new, else decrements.
// - Disable first code only, if enabled and unblocked, then opens files.
// - Enable first code only, if disabled and unblocked.
// - Correct unblock key installs code, resets counters, enables, grants.
// - Wrong key decrements key counter only; ten wrong blocks key.
// - Invalidate sets flag; invalid file only selectable, invalidated or rehabilitated unless rwWhenInval is set.
// - Rehabilitate clears flag, except identity and location files under barred mode without call-control profile.
// - Blocking a code withdraws its session grant at once.
// - Selecting cyclic points newest record; linear leaves pointer unset.
`timescale 1ns/100ps
module crpf_core
    import crpf_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    // Command strobe and payload.
    input  wire logic       cmdValid,
    input  wire crpf_cmd_t  cmd,
    input  wire logic [4:0] patLen,
    input  wire crpf_attr_t fileAttr [NFILE],
    input  wire logic [CODE_W-1:0] initCode [2],
    input  wire logic [CODE_W-1:0] initKey [2],
    input  wire logic       barredMode,
    // Answer.
    output logic            rspValid,
    output crpf_rsp_t       rsp,
    // Status.
    output logic [1:0]      codeBlocked,
    output logic [1:0]      codeGranted,
    output logic            firstDisabled,
    output logic [NFILE-1:0] fileInvalid
);
    // Stored state, with next values.
    logic [REC_W-1:0]  rec_q [NFILE][NREC], rec_d [NFILE][NREC];
    logic [IDX_W-1:0]  oldest_q [NFILE], oldest_d [NFILE];
    logic [FID_W-1:0]  cur_q, cur_d;
    logic [IDX_W-1:0]  ptr_q, ptr_d;
    logic              ptrSet_q, ptrSet_d;
    logic [CODE_W-1:0] code_q [2], code_d [2], key_q [2], key_d [2];
    logic [3:0]        codeCnt_q [2], codeCnt_d [2];
    logic [3:0]        keyCnt_q [2], keyCnt_d [2];
    logic [1:0]        grant_q, grant_d;
    logic              dis_q, dis_d, prof_q, prof_d;
    logic [NFILE-1:0]  inval_q, inval_d;
    logic              loaded_q;
    crpf_rsp_t         rsp_d;

    // Access level check; the second code is never disabled.
    function automatic logic lvlOk(input logic [1:0] lvl,
                                   input logic [1:0] g,
                                   input logic dis);
        case (lvl)
            2'd0:    lvlOk = 1'b1;
            2'd1:    lvlOk = g[0] | dis;
            2'd2:    lvlOk = g[1];
            default: lvlOk = 1'b0;
        endcase
    endfunction

    // Stored position of the newest cyclic record, one above the oldest.
    function automatic logic [IDX_W-1:0] newestOf(input logic [IDX_W-1:0] o);
        newestOf = o + IDX_W'(1);
    endfunction

    // Next-state computation for every command.
    always_comb begin
        crpf_attr_t a;
        logic [IDX_W-1:0] tgt, i;
        logic wr, found, acc, live, rw, csel, hit, tried;
        logic [REC_W:0] sum;
        a = fileAttr[cur_q];
        tgt = '0;
        i = '0;
        wr = 1'b0;
        acc = 1'b0;
        tried = 1'b0;
        found = 1'b0;
        hit = 1'b0;
        sum = '0;
        csel = cmd.codeSel;
        rec_d = rec_q;
        oldest_d = oldest_q;
        cur_d = cur_q;
        ptr_d = ptr_q;
        ptrSet_d = ptrSet_q;
        code_d = code_q;
        key_d = key_q;
        codeCnt_d = codeCnt_q;
        keyCnt_d = keyCnt_q;
        grant_d = grant_q;
        dis_d = dis_q;
        prof_d = prof_q;
        inval_d = inval_q;
        rsp_d = '0;
        rw = ~inval_q[cur_q] | a.rwWhenInval;
        live = (codeCnt_q[csel] != ZERO_TRIES);
        if (cmdValid) begin
            case (cmd.op)
                OP_SELECT: begin
                    cur_d = cmd.fileId;
                    ptrSet_d = fileAttr[cmd.fileId].cyclic;
                    ptr_d = '0;
                    rsp_d.ok = 1'b1;
                end
                OP_UPDATE: begin
                    acc = rw && lvlOk(a.updLvl, grant_q, dis_q);
                    if (a.cyclic) begin
                        if (acc && cmd.mode == MD_PREVIOUS) begin
                            rec_d[cur_q][oldest_q[cur_q]] = cmd.data;
                            oldest_d[cur_q] = oldest_q[cur_q] - IDX_W'(1);
                            ptr_d = '0;
                            wr = 1'b1;
                        end
                    end else if (acc) begin
                        case (cmd.mode)
                            MD_CURRENT: begin
                                wr = ptrSet_q;
                                tgt = ptr_q;
                            end
                            MD_ABSOLUTE: begin
                                wr = 1'b1;
                                tgt = cmd.recNum;
                            end
                            MD_NEXT: begin
                                wr = !ptrSet_q || ptr_q != IDX_W'(NREC-1);
                                tgt = ptrSet_q ? ptr_q + IDX_W'(1) : '0;
                                if (wr) ptr_d = tgt;
                            end
                            default: begin
                                wr = !ptrSet_q || ptr_q != '0;
                                tgt = ptrSet_q ? ptr_q - IDX_W'(1)
                                               : IDX_W'(NREC-1);
                                if (wr) ptr_d = tgt;
                            end
                        endcase
                        if (wr) begin
                            rec_d[cur_q][tgt] = cmd.data;
                            ptrSet_d = 1'b1;
                        end
                    end
                    rsp_d.ok = wr;
                end
                OP_SEARCH: begin
                    acc = !a.cyclic && rw
                        && lvlOk(a.rdLvl, grant_q, dis_q)
                        && patLen >= 5'(PAT_MIN)
                        && patLen <= 5'(PAT_MAX);
                    for (int k = 0; k < NREC; k++) begin
                        case (crpf_seek_t'(cmd.mode))
                            SK_START_FWD: i = IDX_W'(k);
                            SK_END_BWD:   i = IDX_W'(NREC-1-k);
                            SK_NEXT_FWD:  i = ptrSet_q ? ptr_q + IDX_W'(k+1)
                                                       : IDX_W'(k);
                            default:      i = ptrSet_q ? ptr_q - IDX_W'(k+1)
                                                       : IDX_W'(NREC-1-k);
                        endcase
                        hit = (cmd.mode == SK_NEXT_FWD && ptrSet_q)
                            ? (int'(ptr_q) + k + 1 < NREC)
                            : (cmd.mode == SK_PREV_BWD && ptrSet_q)
                            ? (int'(ptr_q) - k - 1 >= 0) : 1'b1;
                        if (!found && hit && rec_q[cur_q][i] == cmd.data) begin
                            found = 1'b1;
                            tgt = i;
                        end
                    end
                    if (acc && found) begin
                        ptr_d = tgt;
                        ptrSet_d = 1'b1;
                        rsp_d.ok = 1'b1;
                        rsp_d.hasRec = cmd.seekType2;
                        rsp_d.recNo = {1'b0, tgt} + (IDX_W+1)'(1);
                    end
                end
                OP_INCREASE: begin
                    acc = a.cyclic && rw
                        && lvlOk(a.incLvl, grant_q, dis_q);
                    sum = {1'b0, rec_q[cur_q][newestOf(oldest_q[cur_q])]}
                        + {1'b0, cmd.data};
                    if (acc && !sum[REC_W]) begin
                        rec_d[cur_q][oldest_q[cur_q]] = sum[REC_W-1:0];
                        oldest_d[cur_q] = oldest_q[cur_q] - IDX_W'(1);
                        ptr_d = '0;
                        rsp_d.ok = 1'b1;
                        rsp_d.value = sum[REC_W-1:0];
                        rsp_d.added = cmd.data;
                    end
                end
                OP_VERIFY, OP_CHANGE, OP_DISABLE, OP_ENABLE: begin
                    if (cmd.op == OP_DISABLE || cmd.op == OP_ENABLE)
                        csel = 1'b0;
                    live = (codeCnt_q[csel] != ZERO_TRIES);
                    acc = live && (cmd.op == OP_ENABLE ? dis_q
                        : (!dis_q || csel));
                    if (acc && cmd.codeA == code_q[csel]) begin
                        codeCnt_d[csel] = CODE_TRIES;
                        grant_d[csel] = 1'b1;
                        if (cmd.op == OP_CHANGE)
                            code_d[csel] = cmd.codeB;
                        if (cmd.op == OP_DISABLE) dis_d = 1'b1;
                        if (cmd.op == OP_ENABLE) dis_d = 1'b0;
                        rsp_d.ok = 1'b1;
                    end else if (acc) begin
                        tried = 1'b1;
                        codeCnt_d[csel] = codeCnt_q[csel] - 4'h1;
                        if (codeCnt_q[csel] == 4'h1)
                            grant_d[csel] = 1'b0;
                    end
                end
                OP_UNBLOCK: begin
                    if (keyCnt_q[csel] != ZERO_TRIES) begin
                        if (cmd.codeA == key_q[csel]) begin
                            code_d[csel] = cmd.codeB;
                            keyCnt_d[csel] = KEY_TRIES;
                            codeCnt_d[csel] = CODE_TRIES;
                            grant_d[csel] = 1'b1;
                            if (!csel) dis_d = 1'b0;
                            rsp_d.ok = 1'b1;
                        end else begin
                            tried = 1'b1;
                            keyCnt_d[csel] = keyCnt_q[csel] - 4'h1;
                        end
                    end
                end
                OP_INVAL: begin
                    if (lvlOk(a.invLvl, grant_q, dis_q)) begin
                        inval_d[cur_q] = 1'b1;
                        rsp_d.ok = 1'b1;
                    end
                end
                OP_REHAB: begin
                    if (lvlOk(a.invLvl, grant_q, dis_q) && !(barredMode
                        && !prof_q && (cur_q == FILE_IDENT
                        || cur_q == FILE_LOC))) begin
                        inval_d[cur_q] = 1'b0;
                        rsp_d.ok = 1'b1;
                    end
                end
                OP_PROFILE: begin
                    prof_d = cmd.callCtrl;
                    rsp_d.ok = 1'b1;
                end
                default: rsp_d.ok = 1'b0;
            endcase
            // A wrong code is a spent attempt, not a refusal: it counts.
            rsp_d.refused = ~rsp_d.ok & ~tried;
        end
    end

    // Registers; secrets load once after reset since they are persistent.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            for (int f = 0; f < NFILE; f++) begin
                oldest_q[f] <= '0;
                for (int r = 0; r < NREC; r++) rec_q[f][r] <= '0;
            end
            for (int c = 0; c < 2; c++) begin
                code_q[c] <= '0;
                key_q[c] <= '0;
                codeCnt_q[c] <= CODE_TRIES;
                keyCnt_q[c] <= KEY_TRIES;
            end
            cur_q <= '0;
            ptr_q <= '0;
            ptrSet_q <= 1'b0;
            grant_q <= '0;
            dis_q <= 1'b0;
            prof_q <= 1'b0;
            inval_q <= '0;
            loaded_q <= 1'b0;
            rspValid <= 1'b0;
            rsp <= '0;
        end else begin
            rec_q <= rec_d;
            oldest_q <= oldest_d;
            cur_q <= cur_d;
            ptr_q <= ptr_d;
            ptrSet_q <= ptrSet_d;
            codeCnt_q <= codeCnt_d;
            keyCnt_q <= keyCnt_d;
            grant_q <= grant_d;
            dis_q <= dis_d;
            prof_q <= prof_d;
            inval_q <= inval_d;
            loaded_q <= 1'b1;
            code_q <= loaded_q ? code_d : initCode;
            key_q <= loaded_q ? key_d : initKey;
            rspValid <= cmdValid;
            rsp <= rsp_d;
        end
    end

    // Status outputs come straight from the state registers.
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            codeBlocked[c] = (codeCnt_q[c] == ZERO_TRIES);
        end
        codeGranted = grant_q;
        firstDisabled = dis_q;
        fileInvalid = inval_q;
    end
endmodule // crpf_core

// ---- design/crpf_pkg.sv ----
/*
 * Package for the card record and holder-code function core.
 * Holds command codes, file kinds, counter limits and the carrier structs.
 * Assumes a single card clock and one session reset.
 */
package crpf_pkg;
    localparam int REC_W   = 8;   // Record data width in bits.
    localparam int NREC    = 8;   // Records per file.
    localparam int IDX_W   = 3;
    localparam int NFILE   = 4;
    localparam int FID_W   = 2;
    localparam int CODE_W  = 32;
    localparam logic [3:0] CODE_TRIES  = 4'h3;
    localparam logic [3:0] KEY_TRIES   = 4'hA;
    localparam logic [3:0] ZERO_TRIES  = 4'h0;
    localparam logic [REC_W-1:0] REC_MAX = 8'hFF;
    localparam int PAT_MIN = 1;
    localparam int PAT_MAX = 16;
    localparam logic [FID_W-1:0] FILE_IDENT = 2'h0;
    localparam logic [FID_W-1:0] FILE_LOC   = 2'h1;

    typedef enum logic [3:0] {
        OP_SELECT   = 4'b0000,
        OP_UPDATE   = 4'b0001,
        OP_SEARCH   = 4'b0010,
        OP_INCREASE = 4'b0011,
        OP_VERIFY   = 4'b0100,
        OP_CHANGE   = 4'b0101,
        OP_DISABLE  = 4'b0110,
        OP_ENABLE   = 4'b0111,
        OP_UNBLOCK  = 4'b1000,
        OP_INVAL    = 4'b1001,
        OP_REHAB    = 4'b1010,
        OP_PROFILE  = 4'b1011
    } crpf_op_t;

    typedef enum logic [1:0] {
        MD_CURRENT  = 2'b00,
        MD_ABSOLUTE = 2'b01,
        MD_NEXT     = 2'b10,
        MD_PREVIOUS = 2'b11
    } crpf_mode_t;

    typedef enum logic [1:0] {
        SK_START_FWD = 2'b00,
        SK_END_BWD   = 2'b01,
        SK_NEXT_FWD  = 2'b10,
        SK_PREV_BWD  = 2'b11
    } crpf_seek_t;

    // One command from the terminal side.
    typedef struct packed {
        crpf_op_t          op;
        crpf_mode_t        mode;       // Update mode or search mode.
        logic              seekType2;
        logic [IDX_W-1:0]  recNum;     // Zero-based absolute record.
        logic [FID_W-1:0]  fileId;
        logic              codeSel;    // 0 first code, 1 second code.
        logic [REC_W-1:0]  data;       // Record data, pattern or addend.
        logic [CODE_W-1:0] codeA;      // Presented code or key.
        logic [CODE_W-1:0] codeB;      // New code.
        logic              callCtrl;   // Profile declares call control.
    } crpf_cmd_t;

    // Result of one command.
    typedef struct packed {
        logic             ok;
        logic             refused;
        logic             hasRec;
        logic [IDX_W:0]   recNo;       // One-based record number.
        logic [REC_W-1:0] value;
        logic [REC_W-1:0] added;
    } crpf_rsp_t;

    // Static attributes of a file.
    typedef struct packed {
        logic       cyclic;
        logic [1:0] updLvl;            // 0 always, 1 first, 2 second, 3 never.
        logic [1:0] rdLvl;
        logic [1:0] incLvl;
        logic [1:0] invLvl;
        logic       rwWhenInval;
    } crpf_attr_t;
endpackage

// ---- dv/crpf_core_asserts.sv ----
/* Checker on the crpf_core ports: answer timing and status effects.
   Assumes one-cycle command strobes. */
`timescale 1ns/100ps
module crpf_core_chk
    import crpf_pkg::*;
(
    // Clock, reset and command.
    input wire logic             clk_sys,
    input wire logic             nrst,
    input wire logic             cmdValid,
    input wire crpf_cmd_t        cmd,
    input wire logic [4:0]       patLen,
    // Answer and status.
    input wire logic             rspValid,
    input wire crpf_rsp_t        rsp,
    input wire logic [1:0]       codeBlocked,
    input wire logic [1:0]       codeGranted,
    input wire logic             firstDisabled,
    input wire logic [NFILE-1:0] fileInvalid
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // A command of one kind followed by a good answer.
    sequence s_ok(crpf_op_t o);
        cmdValid && cmd.op == o ##1 rspValid && rsp.ok;
    endsequence
    // The same command followed by a failing answer.
    sequence s_no(crpf_op_t o);
        cmdValid && cmd.op == o ##1 rspValid && !rsp.ok;
    endsequence
    chk_answer_timing: assert property (cmdValid |=> rspValid)
        else $error("no answer");
    chk_no_stray: assert property (!cmdValid |=> !rspValid)
        else $error("stray answer");
    chk_block_revokes: assert property (
        (codeBlocked & codeGranted) == 2'b00)
        else $error("blocked code grants");
    chk_refuse_frozen: assert property (rspValid && rsp.refused |->
        $stable(codeBlocked) && $stable(codeGranted) &&
        $stable(firstDisabled) && $stable(fileInvalid))
        else $error("refusal changed state");
    chk_disable_sets: assert property (s_ok(OP_DISABLE) |-> firstDisabled)
        else $error("disable failed");
    chk_enable_clears: assert property (s_ok(OP_ENABLE) |-> !firstDisabled)
        else $error("enable failed");
    chk_unblock_grants: assert property (s_ok(OP_UNBLOCK) |->
        codeGranted[$past(cmd.codeSel)] && !codeBlocked[$past(cmd.codeSel)])
        else $error("unblock failed");
    chk_bad_key_keeps: assert property (s_no(OP_UNBLOCK) |->
        $stable(codeBlocked) && $stable(codeGranted) && $stable(firstDisabled))
        else $error("bad key changed code");
    chk_inval_sets: assert property (s_ok(OP_INVAL) |->
        fileInvalid[$past(cmd.fileId)])
        else $error("invalidate failed");
    chk_seek_type: assert property (s_ok(OP_SEARCH) |->
        rsp.hasRec == $past(cmd.seekType2))
        else $error("search type wrong");
    chk_inc_added: assert property (s_ok(OP_INCREASE) |->
        rsp.added == $past(cmd.data) && rsp.value >= rsp.added)
        else $error("increase wrong");
    chk_verify_grants: assert property (s_ok(OP_VERIFY) |->
        codeGranted[$past(cmd.codeSel)])
        else $error("verify failed");
    chk_pat_range: assert property (cmdValid && cmd.op == OP_SEARCH &&
        (patLen == 5'h00 || patLen > 5'h10) |=> rsp.refused)
        else $error("bad length taken");
endmodule // crpf_core_chk

bind crpf_core crpf_core_chk i_chk (.clk_sys(clk_sys), .nrst(nrst),
    .cmdValid(cmdValid), .cmd(cmd), .patLen(patLen), .rspValid(rspValid),
    .rsp(rsp), .codeBlocked(codeBlocked), .codeGranted(codeGranted),
    .firstDisabled(firstDisabled), .fileInvalid(fileInvalid));

// ---- dv/crpf_term.sv ----
/* Terminal model: issues one command and collects its answer.
   Assumes the core answers one cycle after taking a command. */
`timescale 1ns/100ps
module crpf_term
    import crpf_pkg::*;
(
    // Clock and answer.
    input  wire logic      clk_sys,
    input  wire logic      rspValid,
    input  wire crpf_rsp_t rsp,
    // Command.
    output logic           cmdValid,
    output crpf_cmd_t      cmd,
    output logic [4:0]     patLen
);
    // Quiet lines at time zero.
    initial begin
        cmdValid = 1'b0;
        cmd = '0;
        patLen = 5'h01;
    end
    // Fields are inverted after the strobe so stale values never match.
    task automatic issue(input crpf_cmd_t c, input logic [4:0] pl,
                         output logic got, output crpf_rsp_t r);
        @(posedge clk_sys);
        cmdValid <= 1'b1;
        cmd <= c;
        patLen <= pl;
        @(posedge clk_sys);
        cmdValid <= 1'b0;
        cmd <= ~c;
        patLen <= ~pl;
        #1;
        got = rspValid;
        r = rsp;
    endtask
endmodule // crpf_term

// ---- dv/testbench.sv ----
/* Bench for crpf_core: command sequences with expected results.
   Assumes the terminal model returns each answer. */
`timescale 1ns/100ps
module testbench;
    import crpf_pkg::*;
    localparam logic [31:0] C1 = 32'h1111_1111, C2 = 32'h2222_2222,
        C3 = 32'h3333_3333, K1 = 32'hAAAA_AAAA, K2 = 32'hBBBB_BBBB,
        BAD = 32'h0BAD_0BAD;
    logic              clk_sys;
    logic              nrst;
    logic              cmdValid;
    crpf_cmd_t         cmd;
    logic [4:0]        patLen;
    crpf_attr_t        fileAttr [NFILE];
    logic [CODE_W-1:0] initCode [2];
    logic [CODE_W-1:0] initKey [2];
    logic              barredMode;
    logic              rspValid;
    crpf_rsp_t         rsp;
    logic [1:0]        codeBlocked;
    logic [1:0]        codeGranted;
    logic              firstDisabled;
    logic [NFILE-1:0]  fileInvalid;
    crpf_rsp_t         r;
    logic [4:0]        pl;
    int                fails;
    int                n_tests;

    crpf_core i_crpf_core (.clk_sys(clk_sys), .nrst(nrst),
        .cmdValid(cmdValid), .cmd(cmd), .patLen(patLen),
        .fileAttr(fileAttr), .initCode(initCode), .initKey(initKey),
        .barredMode(barredMode), .rspValid(rspValid), .rsp(rsp),
        .codeBlocked(codeBlocked), .codeGranted(codeGranted),
        .firstDisabled(firstDisabled), .fileInvalid(fileInvalid));
    crpf_term i_crpf_term (.clk_sys(clk_sys), .rspValid(rspValid),
        .rsp(rsp), .cmdValid(cmdValid), .cmd(cmd), .patLen(patLen));

    task automatic check(input logic [7:0] s, input logic [7:0] e);
        n_tests++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // One command; x selects type 2, second code or call control.
    task automatic tx(input crpf_op_t op, input logic [1:0] md,
                      input logic [1:0] f, input logic [2:0] rec,
                      input logic [7:0] d, input logic [31:0] a,
                      input logic [31:0] b, input logic x, input logic ok);
        crpf_cmd_t c;
        logic      got;
        c = '0;
        c.op = op;
        c.mode = crpf_mode_t'(md);
        c.seekType2 = x;
        c.recNum = rec;
        c.fileId = f;
        c.codeSel = x;
        c.data = d;
        c.codeA = a;
        c.codeB = b;
        c.callCtrl = x;
        i_crpf_term.issue(c, pl, got, r);
        check(8'(got), 8'h01);
        if (ok !== 1'bx) begin
            check(8'(r.ok), 8'(ok));
        end
    endtask
    task automatic rc(input crpf_op_t op, input logic [1:0] md,
                      input logic [1:0] f, input logic [2:0] rec,
                      input logic [7:0] d, input logic x, input logic ok);
        tx(op, md, f, rec, d, '0, '0, x, ok);
    endtask
    task automatic pc(input crpf_op_t op, input logic s,
                      input logic [31:0] a, input logic [31:0] b,
                      input logic ok);
        tx(op, '0, 2'h2, '0, '0, a, b, s, ok);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Free-running 125 MHz clock.
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Bound: the sequence needs under a thousand cycles.
    initial begin
        repeat (5000) @(posedge clk_sys);
        fails++;
        give_verdict();
    end
    // File 0 open linear, 1 open cyclic, 2 first-code linear, 3 second-code read only.
    initial begin
        fails = 0;
        n_tests = 0;
        pl = 5'h01;
        nrst = 1'b0;
        barredMode = 1'b0;
        fileAttr[0] = 10'h000;
        fileAttr[1] = 10'h200;
        fileAttr[2] = 10'h0A3;
        fileAttr[3] = 10'h1DE;
        initCode[0] = C1;
        initCode[1] = C2;
        initKey[0] = K1;
        initKey[1] = K2;
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rc(OP_SELECT, '0, '0, '0, '0, '0, '1);
        rc(OP_UPDATE, MD_CURRENT, '0, '0, 8'h10, '0, '0);
        rc(OP_UPDATE, MD_NEXT, '0, '0, 8'h10, '0, '1);
        rc(OP_UPDATE, MD_ABSOLUTE, '0, 3'h4, 8'h50, '0, '1);
        rc(OP_UPDATE, MD_NEXT, '0, '0, 8'h20, '0, '1);
        rc(OP_UPDATE, MD_PREVIOUS, '0, '0, 8'h11, '0, '1);
        rc(OP_UPDATE, MD_PREVIOUS, '0, '0, 8'h12, '0, '0);
        rc(OP_SEARCH, SK_START_FWD, '0, '0, 8'h20, '1, '1);
        check(8'(r.recNo), 8'h02);
        rc(OP_SEARCH, SK_START_FWD, '0, '0, 8'h50, '1, '1);
        check(8'(r.recNo), 8'h05);
        rc(OP_SEARCH, SK_START_FWD, '0, '0, 8'h10, '1, '0);
        rc(OP_UPDATE, MD_CURRENT, '0, '0, 8'h55, '0, '1);
        rc(OP_SEARCH, SK_START_FWD, '0, '0, 8'h55, '0, '1);
        check(8'(r.hasRec), 8'h00);
        rc(OP_SEARCH, SK_END_BWD, '0, '0, 8'h11, '1, '1);
        check(8'(r.recNo), 8'h01);
        rc(OP_SELECT, '0, '0, '0, '0, '0, '1);
        rc(OP_SEARCH, SK_PREV_BWD, '0, '0, 8'h55, '1, '1);
        check(8'(r.recNo), 8'h05);
        rc(OP_SELECT, '0, '0, '0, '0, '0, '1);
        rc(OP_UPDATE, MD_PREVIOUS, '0, '0, 8'h80, '0, '1);
        rc(OP_UPDATE, MD_NEXT, '0, '0, 8'h81, '0, '0);
        rc(OP_SEARCH, SK_NEXT_FWD, '0, '0, 8'h80, '1, '0);
        pl = 5'h11;
        rc(OP_SEARCH, SK_START_FWD, '0, '0, 8'h80, '1, '0);
        pl = 5'h10;
        rc(OP_SEARCH, SK_START_FWD, '0, '0, 8'h80, '1, '1);
        check(8'(r.recNo), 8'h08);
        pl = 5'h01;
        rc(OP_SELECT, '0, 2'h1, '0, '0, '0, '1);
        rc(OP_UPDATE, MD_NEXT, 2'h1, '0, 8'h01, '0, '0);
        rc(OP_UPDATE, MD_ABSOLUTE, 2'h1, '0, 8'h01, '0, '0);
        rc(OP_UPDATE, MD_PREVIOUS, 2'h1, '0, 8'hF0, '0, '1);
        rc(OP_INCREASE, '0, 2'h1, '0, 8'h0E, '0, '1);
        check(r.value, 8'hFE);
        rc(OP_INCREASE, '0, 2'h1, '0, 8'h02, '0, '0);
        rc(OP_INCREASE, '0, 2'h1, '0, 8'h01, '0, '1);
        check(r.value, 8'hFF);
        rc(OP_SEARCH, SK_START_FWD, 2'h1, '0, 8'hFF, '0, '0);
        rc(OP_SELECT, '0, 2'h2, '0, '0, '0, '1);
        rc(OP_UPDATE, MD_ABSOLUTE, 2'h2, '0, 8'h33, '0, '0);
        rc(OP_SEARCH, SK_START_FWD, 2'h2, '0, 8'h33, '0, '0);
        pc(OP_VERIFY, '0, C1, '0, '1);
        rc(OP_UPDATE, MD_ABSOLUTE, 2'h2, '0, 8'h33, '0, '1);
        repeat (3) pc(OP_VERIFY, '0, BAD, '0, '0);
        check(8'(codeBlocked), 8'h01);
        check(8'(codeGranted), 8'h00);
        pc(OP_VERIFY, '0, C1, '0, '0);
        rc(OP_UPDATE, MD_ABSOLUTE, 2'h2, '0, 8'h34, '0, '0);
        pc(OP_DISABLE, '0, C1, '0, '0);
        pc(OP_UNBLOCK, '0, BAD, C3, '0);
        pc(OP_UNBLOCK, '0, K1, C3, '1);
        check(8'(codeGranted), 8'h01);
        pc(OP_CHANGE, '0, BAD, C1, '0);
        pc(OP_CHANGE, '0, C3, C1, '1);
        pc(OP_VERIFY, '0, C3, '0, '0);
        pc(OP_ENABLE, '0, C1, '0, '0);
        pc(OP_DISABLE, '1, C2, '0, '0);
        pc(OP_DISABLE, '0, C1, '0, '1);
        pc(OP_VERIFY, '0, C1, '0, '0);
        pc(OP_ENABLE, '0, BAD, '0, '0);
        check(8'(firstDisabled), 8'h01);
        pc(OP_ENABLE, '0, C1, '0, '1);
        repeat (9) pc(OP_UNBLOCK, '1, BAD, C2, '0);
        pc(OP_UNBLOCK, '1, K2, C2, '1);
        repeat (10) pc(OP_UNBLOCK, '1, BAD, C2, '0);
        pc(OP_UNBLOCK, '1, K2, C2, '0);
        rc(OP_SELECT, '0, 2'h3, '0, '0, '0, '1);
        rc(OP_INVAL, '0, 2'h3, '0, '0, '0, '0);
        rc(OP_SELECT, '0, 2'h2, '0, '0, '0, '1);
        rc(OP_INVAL, '0, 2'h2, '0, '0, '0, '1);
        rc(OP_UPDATE, MD_ABSOLUTE, 2'h2, 3'h1, 8'h44, '0, '1);
        rc(OP_SELECT, '0, '0, '0, '0, '0, '1);
        rc(OP_INVAL, '0, '0, '0, '0, '0, '1);
        rc(OP_UPDATE, MD_ABSOLUTE, '0, '0, 8'h44, '0, '0);
        @(posedge clk_sys);
        barredMode <= 1'b1;
        rc(OP_REHAB, '0, '0, '0, '0, '0, '0);
        check(8'(fileInvalid), 8'h05);
        rc(OP_PROFILE, '0, '0, '0, '0, '1, '1);
        rc(OP_REHAB, '0, '0, '0, '0, '0, '1);
        check(8'(fileInvalid), 8'h04);
        give_verdict();
    end
endmodule // testbench
